// *** rtl/branch_record_pkg.sv ***
// Constants shared by the branch history stack design
package branch_record_pkg;

  // Address record formats reported in the capability register
  localparam logic [5:0] FMT_CS_OFFSET32 = 6'h00;
  localparam logic [5:0] FMT_LIN64       = 6'h01;
  localparam logic [5:0] FMT_EFF64       = 6'h02;
  localparam logic [5:0] FMT_EFF64_MISP  = 6'h03;
  localparam logic [5:0] FMT_EFF64_TX    = 6'h04;
  localparam logic [5:0] FMT_EFF64_INFO  = 6'h05;
  localparam logic [5:0] FMT_LIN64_CYC   = 6'h06;
  localparam logic [5:0] FMT_LIN64_INFO  = 6'h07;

  // Field positions
  localparam int FMT_LSB        = 0;
  localparam int FMT_MSB        = 5;
  localparam int MISP_BIT       = 63;
  localparam int TX_BIT         = 62;
  localparam int TX_ABORT_BIT   = 61;
  localparam int CYC_LSB        = 48;
  localparam int CYC_W          = 16;
  localparam int HALF_W         = 32;
  localparam int CAP_PRESENT_BIT = 15;
  localparam int DBG_ENABLE_BIT = 0;

  // Register selector codes on the register port
  localparam logic [1:0] SEL_SOURCE = 2'h0;
  localparam logic [1:0] SEL_DEST   = 2'h1;
  localparam logic [1:0] SEL_INFO   = 2'h2;
  localparam logic [1:0] SEL_MISC   = 2'h3;

  // Miscellaneous register indices within SEL_MISC
  localparam logic [4:0] MISC_TOP   = 5'h00;
  localparam logic [4:0] MISC_CAP   = 5'h01;
  localparam logic [4:0] MISC_DBG   = 5'h02;

  localparam logic [63:0] ZERO64    = 64'h0;

endpackage : branch_record_pkg

// *** rtl/entry_store.sv ***
// Entry memory with registered read data
`timescale 1ns/100ps
module entry_store #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 64,
  parameter int AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule : entry_store

// *** rtl/branch_history_stack.sv ***
// Circular branch history stack with register port
// How it works
// - Holds DEPTH pairs of source and destination addresses.
// - DEPTH is 32, 16, 8 or 4; pointer spans 0 to DEPTH-1.
// - Records branches, interrupts, traps and faults alike.
// - Low pointer bits index the most recent record.
// - Source and destination entries sit at consecutive indices of own ranges.
// - Entries are 64 bits; address bits 63:32 zero outside 64-bit mode.
// - Read-only format field bits 5:0 reports the address format.
// - Format 3: misprediction flag in source top bit.
// - Format 4: misprediction and transactional status in source upper bits.
// - Format 5: flags and cycles kept in per-entry info stack.
// - Format 6: linear address; cycles in destination upper 16 bits.
// - Format 7: linear address; misprediction and cycles in info stack.
// - Capability register presence shown by feature bit 15.
// - Legacy format packs 32-bit destination high, source low.
// - Info stack exists only when the model has one.
// - Recording only while debug control bit 0 is set.
`timescale 1ns/100ps
module branch_history_stack #(
  parameter int         DEPTH    = 32,
  parameter logic [5:0] FORMAT   = branch_record_pkg::FMT_EFF64_INFO,
  parameter bit         HAS_INFO = 1'b1,
  parameter int         AW       = $clog2(DEPTH)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Transfer report from the retirement logic
  input  wire logic        xfer_valid,
  input  wire logic [63:0] xfer_source,
  input  wire logic [63:0] xfer_dest,
  input  wire logic [63:0] xfer_linear_base,
  input  wire logic        xfer_long_mode,
  input  wire logic        xfer_mispredict,
  input  wire logic        xfer_in_tx,
  input  wire logic        xfer_tx_abort,
  // Register port
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [1:0]  reg_sel,
  input  wire logic [4:0]  reg_idx,
  input  wire logic [63:0] reg_wdata,
  output logic      [63:0] reg_rdata,
  output logic             reg_rvalid,
  output logic             feature_cap_present
);

  // ==========================================================
  // Control state
  logic [AW-1:0] top_q;
  logic          enable_q;
  localparam int CYCW = branch_record_pkg::CYC_W;
  logic [CYCW-1:0] cycles_q;

  wire logic record = xfer_valid & enable_q;
  wire logic [AW-1:0] next_top = (top_q == AW'(DEPTH - 1)) ? '0 : top_q + 1'b1;
  wire logic ctrl_wr = reg_wr && reg_sel == branch_record_pkg::SEL_MISC
                       && reg_idx == branch_record_pkg::MISC_DBG;

  always_ff @(posedge clk) begin
    if (rst) begin
      top_q <= '0;
    end else if (record) begin
      top_q <= next_top;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_q <= 1'b0;
    end else if (ctrl_wr) begin
      enable_q <= reg_wdata[branch_record_pkg::DBG_ENABLE_BIT];
    end
  end

  // Saturating cycle count since the previous record
  // Record edge itself counts as one elapsed cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cycles_q <= '0;
    end else if (record) begin
      cycles_q <= CYCW'(1);
    end else if (cycles_q != '1) begin
      cycles_q <= cycles_q + 1'b1;
    end
  end


  // ==========================================================
  // Address formatting
  logic [63:0] src_w, dst_w, info_w, src_a, dst_a;

  always_comb begin
    src_a = xfer_source;
    dst_a = xfer_dest;
    if (FORMAT == branch_record_pkg::FMT_LIN64 || FORMAT == branch_record_pkg::FMT_LIN64_CYC
        || FORMAT == branch_record_pkg::FMT_LIN64_INFO) begin
      src_a = xfer_source + xfer_linear_base;
      dst_a = xfer_dest + xfer_linear_base;
    end
    if (!xfer_long_mode) begin
      src_a[63:32] = '0;
      dst_a[63:32] = '0;
    end
  end

  always_comb begin
    src_w  = src_a;
    dst_w  = dst_a;
    info_w = '0;
    case (FORMAT)
      branch_record_pkg::FMT_CS_OFFSET32: begin
        src_w = {32'h0, src_a[31:0]};
        dst_w = {32'h0, dst_a[31:0]};
        // Legacy layout: destination high half, source low half
        src_w = {dst_a[31:0], src_a[31:0]};
        dst_w = {dst_a[31:0], src_a[31:0]};
      end
      branch_record_pkg::FMT_EFF64_MISP: begin
        src_w[branch_record_pkg::MISP_BIT] = xfer_mispredict;
      end
      branch_record_pkg::FMT_EFF64_TX: begin
        src_w[branch_record_pkg::MISP_BIT]     = xfer_mispredict;
        src_w[branch_record_pkg::TX_BIT]       = xfer_in_tx;
        src_w[branch_record_pkg::TX_ABORT_BIT] = xfer_tx_abort;
      end
      branch_record_pkg::FMT_EFF64_INFO: begin
        info_w[branch_record_pkg::MISP_BIT]     = xfer_mispredict;
        info_w[branch_record_pkg::TX_BIT]       = xfer_in_tx;
        info_w[branch_record_pkg::TX_ABORT_BIT] = xfer_tx_abort;
        info_w[CYCW-1:0]                        = cycles_q;
      end
      branch_record_pkg::FMT_LIN64_CYC: begin
        src_w[branch_record_pkg::MISP_BIT] = xfer_mispredict;
        dst_w[63:branch_record_pkg::CYC_LSB] = cycles_q;
      end
      branch_record_pkg::FMT_LIN64_INFO: begin
        info_w[branch_record_pkg::MISP_BIT] = xfer_mispredict;
        info_w[CYCW-1:0]                    = cycles_q;
      end
      default: begin
        src_w = src_a;
      end
    endcase
  end

  // ==========================================================
  // Entry stacks: source, destination, optional info
  logic [63:0] src_rd, dst_rd, info_rd;
  wire logic [AW-1:0] raddr = reg_idx[AW-1:0];

  entry_store #(.DEPTH(DEPTH), .WIDTH(64), .AW(AW)) u_src (
    .clk   (clk),
    .we    (record),
    .waddr (next_top),
    .wdata (src_w),
    .raddr (raddr),
    .rdata (src_rd)
  );

  entry_store #(.DEPTH(DEPTH), .WIDTH(64), .AW(AW)) u_dst (
    .clk   (clk),
    .we    (record),
    .waddr (next_top),
    .wdata (dst_w),
    .raddr (raddr),
    .rdata (dst_rd)
  );

  generate
    if (HAS_INFO) begin : g_info
      entry_store #(.DEPTH(DEPTH), .WIDTH(64), .AW(AW)) u_info (
        .clk   (clk),
        .we    (record),
        .waddr (next_top),
        .wdata (info_w),
        .raddr (raddr),
        .rdata (info_rd)
      );
    end else begin : g_noinfo
      assign info_rd = '0;
    end
  endgenerate

  // ==========================================================
  // Register read path, data two cycles after the request
  logic [1:0] sel_q;
  logic [4:0] idx_q;
  logic       rd_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= '0;
      idx_q <= '0;
      rd_q  <= 1'b0;
    end else begin
      sel_q <= reg_sel;
      idx_q <= reg_idx;
      rd_q  <= reg_rd;
    end
  end

  logic [63:0] misc_d, rdata_d;
  always_comb begin
    case (reg_idx)
      branch_record_pkg::MISC_TOP: misc_d = 64'(top_q);
      branch_record_pkg::MISC_CAP: misc_d = 64'(FORMAT);
      branch_record_pkg::MISC_DBG: misc_d = 64'(enable_q);
      default:                     misc_d = branch_record_pkg::ZERO64;
    endcase
  end

  logic [63:0] misc_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      misc_q <= '0;
    end else begin
      misc_q <= misc_d;
    end
  end

  wire logic idx_ok = {1'b0, idx_q} < 6'(DEPTH);
  always_comb begin
    case (sel_q)
      branch_record_pkg::SEL_SOURCE: rdata_d = idx_ok ? src_rd : '0;
      branch_record_pkg::SEL_DEST:   rdata_d = idx_ok ? dst_rd : '0;
      branch_record_pkg::SEL_INFO:   rdata_d = (idx_ok && HAS_INFO) ? info_rd : '0;
      default:                       rdata_d = misc_q;
    endcase
  end

  // Outputs from flip-flops: data two cycles after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= rd_q ? rdata_d : '0;
      reg_rvalid <= rd_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      feature_cap_present <= 1'b0;
    end else begin
      feature_cap_present <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  a_top_advance: assert property (@(posedge clk) disable iff (rst)
    record |=> top_q == (($past(top_q) == AW'(DEPTH - 1)) ? '0 : $past(top_q) + 1'b1))
    else $error("Pointer did not advance");
  a_top_hold: assert property (@(posedge clk) disable iff (rst)
    !enable_q |=> $stable(top_q))
    else $error("Pointer moved while disabled");
  a_top_range: assert property (@(posedge clk) disable iff (rst)
    top_q <= AW'(DEPTH - 1))
    else $error("Pointer out of range");
  a_read_latency: assert property (@(posedge clk) disable iff (rst)
    reg_rd |-> ##2 reg_rvalid)
    else $error("Read answer late");
  a_cap_format: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_sel == branch_record_pkg::SEL_MISC && reg_idx == branch_record_pkg::MISC_CAP
    |-> ##2 reg_rdata[5:0] == FORMAT && reg_rdata[63:6] == '0)
    else $error("Format field wrong");
  a_upper_zero: assert property (@(posedge clk) disable iff (rst)
    record && !xfer_long_mode && (FORMAT == branch_record_pkg::FMT_EFF64
    || FORMAT == branch_record_pkg::FMT_EFF64_INFO)
    |-> src_w[63:32] == '0 && dst_w[63:32] == '0)
    else $error("Upper half not cleared");
  a_misp_flag: assert property (@(posedge clk) disable iff (rst)
    record && (FORMAT == branch_record_pkg::FMT_EFF64_MISP
    || FORMAT == branch_record_pkg::FMT_EFF64_INFO)
    |-> (FORMAT == branch_record_pkg::FMT_EFF64_MISP ? src_w[63] : info_w[63]) == xfer_mispredict)
    else $error("Misprediction flag lost");
  a_top_readback: assert property (@(posedge clk) disable iff (rst)
    reg_rd && !record && reg_sel == branch_record_pkg::SEL_MISC
    && reg_idx == branch_record_pkg::MISC_TOP |-> ##2 reg_rdata == 64'($past(top_q, 2)))
    else $error("Pointer readback wrong");
  a_cap_bit: assert property (@(posedge clk) disable iff (rst)
    $past(rst) == 1'b0 |-> feature_cap_present)
    else $error("Capability presence low");
  a_rvalid_idle: assert property (@(posedge clk) disable iff (rst)
    !rd_q |=> !reg_rvalid)
    else $error("Read answer without request");
  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !reg_rvalid |-> reg_rdata == '0)
    else $error("Read data not zero while idle");
  a_beyond_depth: assert property (@(posedge clk) disable iff (rst)
    rd_q && sel_q != branch_record_pkg::SEL_MISC && !idx_ok |=> reg_rdata == '0)
    else $error("Read beyond depth not zero");
  a_enable_write: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> enable_q == $past(reg_wdata[branch_record_pkg::DBG_ENABLE_BIT]))
    else $error("Enable bit not written");
  a_cycles_restart: assert property (@(posedge clk) disable iff (rst)
    record |=> cycles_q == CYCW'(1))
    else $error("Cycle count not restarted");
  a_long_mode_full: assert property (@(posedge clk) disable iff (rst)
    record && xfer_long_mode && FORMAT == branch_record_pkg::FMT_EFF64_INFO
    |-> src_w == xfer_source && dst_w == xfer_dest)
    else $error("Full address not kept");
  a_cap_steady: assert property (@(posedge clk) disable iff (rst)
    feature_cap_present |=> feature_cap_present)
    else $error("Capability presence dropped");

endmodule : branch_history_stack

// *** verification/retire_model.sv ***
// Retirement-side model that reports control transfers to the stack
`timescale 1ns/100ps
module retire_model (
  input  wire logic        clk,
  output logic             xfer_valid,
  output logic      [63:0] xfer_source,
  output logic      [63:0] xfer_dest,
  output logic      [63:0] xfer_linear_base,
  output logic             xfer_long_mode,
  output logic             xfer_mispredict,
  output logic             xfer_in_tx,
  output logic             xfer_tx_abort
);
  initial begin
    xfer_valid       = 1'b0;
    xfer_source      = 64'h0;
    xfer_dest        = 64'h0;
    xfer_linear_base = 64'h0000_7000_0000_0000;
    xfer_long_mode   = 1'b0;
    {xfer_mispredict, xfer_in_tx, xfer_tx_abort} = 3'h0;
  end

  // One-cycle transfer report; any kind of transfer looks alike here
  task automatic send(input logic [63:0] src, input logic [63:0] dst, input logic lm,
                      input logic [2:0] flg);
    @(posedge clk);
    #1;
    xfer_valid     = 1'b1;
    xfer_source    = src;
    xfer_dest      = dst;
    xfer_long_mode = lm;
    {xfer_mispredict, xfer_in_tx, xfer_tx_abort} = flg;
    @(posedge clk);
    #1;
    xfer_valid     = 1'b0;
    // Released qualifiers show inverse data
    xfer_source    = ~src;
    xfer_dest      = ~dst;
    xfer_long_mode = ~lm;
    {xfer_mispredict, xfer_in_tx, xfer_tx_abort} = ~flg;
    xfer_linear_base = ~xfer_linear_base;
  endtask : send
endmodule : retire_model

// *** verification/test_branch_history_stack.sv ***
// Self-checking bench for the branch history stack
`timescale 1ns/100ps
module test_branch_history_stack;
  localparam int T = 25;
  localparam int DEPTH = 4;
  logic clk, rst, reg_rd, reg_wr, feature_cap_present, reg_rvalid;
  logic xfer_valid, xfer_long_mode, xfer_mispredict, xfer_in_tx, xfer_tx_abort;
  logic [63:0] xfer_source, xfer_dest, xfer_linear_base, reg_wdata, reg_rdata, got;
  logic [1:0]  reg_sel;
  logic [4:0]  reg_idx;
  int          bad_count, comparisons;

  initial clk = 1'b0;
  always #(T/2.0) clk = ~clk;

  retire_model model (.clk(clk), .xfer_valid(xfer_valid), .xfer_source(xfer_source),
    .xfer_dest(xfer_dest), .xfer_linear_base(xfer_linear_base),
    .xfer_long_mode(xfer_long_mode), .xfer_mispredict(xfer_mispredict),
    .xfer_in_tx(xfer_in_tx), .xfer_tx_abort(xfer_tx_abort));

  branch_history_stack #(.DEPTH(DEPTH), .FORMAT(branch_record_pkg::FMT_EFF64_INFO),
    .HAS_INFO(1'b1)) dut (.clk(clk), .rst(rst), .xfer_valid(xfer_valid),
    .xfer_source(xfer_source), .xfer_dest(xfer_dest), .xfer_linear_base(xfer_linear_base),
    .xfer_long_mode(xfer_long_mode), .xfer_mispredict(xfer_mispredict),
    .xfer_in_tx(xfer_in_tx), .xfer_tx_abort(xfer_tx_abort), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .feature_cap_present(feature_cap_present));

  // ==========================================
  // Compare and register tasks
  task automatic check64(input string name, input logic [63:0] exp, input logic [63:0] act);
    comparisons++;
    if (act !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, act);
    end
  endtask : check64

  task automatic reg_op(input logic wr, input logic [1:0] sel, input logic [4:0] idx,
                        input logic [63:0] wd);
    @(posedge clk);
    #1;
    reg_rd = ~wr;
    reg_wr = wr;
    reg_sel = sel;
    reg_idx = idx;
    reg_wdata = wd;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    @(posedge clk);
    #1;
    got = reg_rdata;
    if (!wr) check64("reg_rvalid", 64'h1, {63'h0, reg_rvalid});
  endtask : reg_op

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // ==========================================
  // Scenarios
  task automatic test_reset;
    reg_op(1'b0, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_TOP, 64'h0);
    check64("top_pointer", 64'h0, got);
    reg_op(1'b0, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_CAP, 64'h0);
    check64("format", {58'h0, branch_record_pkg::FMT_EFF64_INFO}, got);
    reg_op(1'b1, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_CAP, 64'h3f);
    reg_op(1'b0, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_CAP, 64'h0);
    check64("format_ro", {58'h0, branch_record_pkg::FMT_EFF64_INFO}, got);
    check64("cap_present", 64'h1, {63'h0, feature_cap_present});
    $display("test_reset done");
  endtask : test_reset

  task automatic test_disabled;
    model.send(64'h0000_0000_0000_1234, 64'h0000_0000_0000_5678, 1'b1, 3'h0);
    reg_op(1'b0, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_TOP, 64'h0);
    check64("top_disabled", 64'h0, got);
    $display("test_disabled done");
  endtask : test_disabled

  task automatic test_record_wrap;
    logic [63:0] src, dst;
    reg_op(1'b1, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_DBG, 64'h1);
    for (int i = 0; i < DEPTH + 2; i++) begin
      src = 64'hffff_8000_0000_1000 + 64'(i);
      dst = 64'h0000_7fff_0000_2000 + 64'(i);
      model.send(src, dst, 1'b1, 3'(i + 3));
      reg_op(1'b0, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_TOP, 64'h0);
      check64("top_pointer", 64'((i + 1) % DEPTH), got);
      reg_op(1'b0, branch_record_pkg::SEL_SOURCE, 5'((i + 1) % DEPTH), 64'h0);
      check64("source_entry", src, got);
      reg_op(1'b0, branch_record_pkg::SEL_DEST, 5'((i + 1) % DEPTH), 64'h0);
      check64("dest_entry", dst, got);
      reg_op(1'b0, branch_record_pkg::SEL_INFO, 5'((i + 1) % DEPTH), 64'h0);
      check64("info_flags", {3'(i + 3), 61'h0}, {got[63:61], 61'h0});
      // Records 14 cycles apart: four reads of three cycles plus the send
      if (i > 0) check64("info_cycles", 64'h000e, {48'h0, got[15:0]});
    end
    $display("test_record_wrap done");
  endtask : test_record_wrap

  task automatic test_short_mode;
    model.send(64'habcd_0000_1111_2222, 64'h1234_0000_3333_4444, 1'b0, 3'h0);
    reg_op(1'b0, branch_record_pkg::SEL_SOURCE, 5'((DEPTH + 3) % DEPTH), 64'h0);
    check64("source_short", 64'h0000_0000_1111_2222, got);
    reg_op(1'b0, branch_record_pkg::SEL_DEST, 5'((DEPTH + 3) % DEPTH), 64'h0);
    check64("dest_short", 64'h0000_0000_3333_4444, got);
    $display("test_short_mode done");
  endtask : test_short_mode

  task automatic test_refused;
    reg_op(1'b1, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_TOP, 64'h2);
    reg_op(1'b0, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_TOP, 64'h0);
    check64("top_ro", 64'((DEPTH + 3) % DEPTH), got);
    reg_op(1'b0, branch_record_pkg::SEL_SOURCE, 5'(DEPTH), 64'h0);
    check64("beyond_depth", 64'h0, got);
    reg_op(1'b1, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_DBG, 64'h0);
    model.send(64'h55, 64'h66, 1'b1, 3'h0);
    reg_op(1'b0, branch_record_pkg::SEL_MISC, branch_record_pkg::MISC_TOP, 64'h0);
    check64("top_after_off", 64'((DEPTH + 3) % DEPTH), got);
    $display("test_refused done");
  endtask : test_refused

  // ==========================================
  // Main sequence and watchdog
  initial begin
    {rst, reg_rd, reg_wr, reg_sel, reg_idx, reg_wdata} = '0;
    bad_count = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    test_reset();
    test_disabled();
    test_record_wrap();
    test_short_mode();
    test_refused();
    end_sim();
  end

  initial begin
    #(T * 3000);
    bad_count++;
    end_sim();
  end
endmodule : test_branch_history_stack
